// >>> hdl/bxe_bit_store.sv
// bit-addressable ram, status word and port latches
`default_nettype none
module bxe_bit_store (
    input  wire logic clk,
    input  wire logic resetn,
    bxe_bus_if.store  bus
);
    logic [127:0] ram_bits;
    logic [7:0]   program_status_word;
    logic [7:0]   port [4];
    logic         rd;
    logic [2:0]   pidx;

    function automatic logic is_sfr(input logic [7:0] a);
        return a >= bxe_pkg::SFR_BIT_SPLIT;
    endfunction

    // port index for sfr bit address, 4 = not a port
    function automatic logic [2:0] port_idx(input logic [7:0] a);
        unique case ({a[7:3], 3'h0})
            bxe_pkg::P0_ADDR: port_idx = 3'h0;
            bxe_pkg::P1_ADDR: port_idx = 3'h1;
            bxe_pkg::P2_ADDR: port_idx = 3'h2;
            bxe_pkg::P3_ADDR: port_idx = 3'h3;
            default:          port_idx = 3'h4;
        endcase
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ram_bits <= '0;
        end else if (bus.bit_we && !is_sfr(bus.bit_addr)) begin
            ram_bits[bus.bit_addr[6:0]] <= bus.bit_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            program_status_word <= bxe_pkg::PSW_RESET;
        end else if (bus.bit_we && {bus.bit_addr[7:3], 3'h0} == bxe_pkg::PSW_ADDR) begin
            program_status_word[bus.bit_addr[2:0]] <= bus.bit_wdata;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_port
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                port[g] <= bxe_pkg::PORT_RESET;
            end else if (bus.bit_we && port_idx(bus.bit_addr) == 3'(g)) begin
                port[g][bus.bit_addr[2:0]] <= bus.bit_wdata;
            end
        end
    end

    assign pidx = port_idx(bus.bit_addr);

    always_comb begin
        rd = 1'b0;
        if (!is_sfr(bus.bit_addr)) begin
            rd = ram_bits[bus.bit_addr[6:0]];
        end else if ({bus.bit_addr[7:3], 3'h0} == bxe_pkg::PSW_ADDR) begin
            rd = program_status_word[bus.bit_addr[2:0]];
        end else if (pidx != 3'h4) begin
            rd = port[pidx[1:0]][bus.bit_addr[2:0]];
        end
    end

    assign bus.bit_rdata = rd;
    assign bus.program_status_word = program_status_word;
    assign bus.p0  = port[0];
    assign bus.p1  = port[1];
    assign bus.p2  = port[2];
    assign bus.p3  = port[3];
endmodule
`default_nettype wire

// >>> hdl/bxe_exec.sv
// executes external moves, table reads, bit ops and bit jumps
`default_nettype none
module bxe_exec #(
    parameter int unsigned MCYCLE_CLKS = bxe_pkg::MCYCLE_CLKS
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 start,
    input  wire bxe_pkg::bxe_op_t     op,
    input  wire logic [7:0]           bit_addr,
    input  wire logic [7:0]           rel,
    input  wire logic                 ptr_sel,
    input  wire logic [7:0]           r0,
    input  wire logic [7:0]           r1,
    input  wire logic [15:0]          dptr,
    input  wire logic [15:0]          pc_next,
    input  wire logic [7:0]           acc_load,
    input  wire logic                 acc_load_en,
    input  wire logic [7:0]           ext_din,
    input  wire logic [7:0]           code_din,
    output logic                      busy,
    output logic                      done,
    output logic [15:0]               pc_out,
    output logic                      pc_load,
    output logic [7:0]                acc,
    output logic                      carry,
    output logic [7:0]                p0_out,
    output logic [7:0]                p0_oe,
    output logic [7:0]                p1_out,
    output logic [7:0]                p2_out,
    output logic                      p2_addr_mode,
    output logic [7:0]                p3_out,
    output logic [15:0]               ext_addr,
    output logic                      ext_rd_n,
    output logic                      ext_wr_n,
    output logic                      program_store_strobe_n,
    output logic [7:0]                ext_dout
);
    if (MCYCLE_CLKS < 2) begin : g_bad_mcycle
        $error("MCYCLE_CLKS must be at least 2");
    end

    localparam int CW = $clog2(MCYCLE_CLKS + 1);

    typedef enum logic [1:0] {BXE_IDLE, BXE_RUN, BXE_FINISH} bxe_state_t;

    bxe_bus_if bus ();
    bxe_bit_store u_store (
        .clk    (clk),
        .resetn (resetn),
        .bus    (bus)
    );

    bxe_state_t       state;
    bxe_pkg::bxe_op_t cur_op;
    logic [CW-1:0]    clk_cnt;
    logic [1:0]       mcyc;
    logic [1:0]       mcyc_need;
    logic             mtick;
    logic [7:0]       cur_bit;
    logic [7:0]       cur_rel;
    logic [15:0]      cur_addr;
    logic             bit_val;

    function automatic logic is_xmove(input bxe_pkg::bxe_op_t o);
        return o inside {bxe_pkg::BXE_XRD_PTR8, bxe_pkg::BXE_XWR_PTR8,
                         bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16};
    endfunction

    function automatic logic is_xwrite(input bxe_pkg::bxe_op_t o);
        return o inside {bxe_pkg::BXE_XWR_PTR8, bxe_pkg::BXE_XWR_PTR16};
    endfunction

    // one or two machine cycles per operation
    function automatic logic [1:0] cycles_of(input bxe_pkg::bxe_op_t o);
        unique case (o)
            bxe_pkg::BXE_MOV_C_BIT, bxe_pkg::BXE_CLR_C, bxe_pkg::BXE_CLR_BIT,
            bxe_pkg::BXE_SET_C, bxe_pkg::BXE_SET_BIT, bxe_pkg::BXE_CPL_C,
            bxe_pkg::BXE_CPL_BIT, bxe_pkg::BXE_NOP: cycles_of = 2'd1;
            default: cycles_of = 2'(bxe_pkg::XMOVE_MCYCLES);
        endcase
    endfunction

    // direct bit address only; carry via psw bit address
    assign bus.bit_addr = (state == BXE_IDLE) ? bit_addr : cur_bit;
    assign bit_val = bus.bit_rdata;

    // machine cycle divider, 12 oscillator periods each
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_cnt <= '0;
        end else if (state != BXE_RUN || mtick) begin
            clk_cnt <= '0;
        end else begin
            clk_cnt <= clk_cnt + CW'(1);
        end
    end
    assign mtick = (state == BXE_RUN) && (clk_cnt == CW'(MCYCLE_CLKS - 1));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= BXE_IDLE;
            cur_op    <= bxe_pkg::BXE_NOP;
            cur_bit   <= '0;
            cur_rel   <= '0;
            mcyc      <= '0;
            mcyc_need <= 2'd1;
        end else begin
            unique case (state)
                BXE_IDLE: if (start) begin
                    state     <= BXE_RUN;
                    cur_op    <= op;
                    cur_bit   <= bit_addr;
                    cur_rel   <= rel;
                    mcyc      <= '0;
                    mcyc_need <= cycles_of(op);
                end
                BXE_RUN: if (mtick) begin
                    mcyc <= mcyc + 2'd1;
                    if (mcyc + 2'd1 == mcyc_need) state <= BXE_FINISH;
                end
                BXE_FINISH: state <= BXE_IDLE;
            endcase
        end
    end

    // operand address latch; pointer forms and table reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_addr <= '0;
        end else if (state == BXE_IDLE && start) begin
            unique case (op)
                bxe_pkg::BXE_XRD_PTR8, bxe_pkg::BXE_XWR_PTR8:
                    cur_addr <= {8'h00, ptr_sel ? r1 : r0};
                bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16:
                    cur_addr <= dptr;
                bxe_pkg::BXE_CRD_DPTR: cur_addr <= dptr + {8'h00, acc};
                bxe_pkg::BXE_CRD_PC:   cur_addr <= pc_next + {8'h00, acc};
                default:               cur_addr <= cur_addr;
            endcase
        end
    end

    // external bus strobes and address
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_addr               <= '0;
            ext_rd_n               <= 1'b1;
            ext_wr_n               <= 1'b1;
            program_store_strobe_n <= 1'b1;
            ext_dout               <= '0;
            p2_addr_mode           <= 1'b0;
        end else begin
            ext_addr <= cur_addr;
            // strobes only inside external moves
            ext_rd_n <= !(state == BXE_RUN && is_xmove(cur_op) && !is_xwrite(cur_op));
            ext_wr_n <= !(state == BXE_RUN && is_xwrite(cur_op));
            // table reads are read-only, strobed by program store
            program_store_strobe_n <= !(state == BXE_RUN &&
                (cur_op == bxe_pkg::BXE_CRD_DPTR || cur_op == bxe_pkg::BXE_CRD_PC));
            ext_dout <= acc;
            // wide pointer claims all of port 2
            p2_addr_mode <= state == BXE_RUN &&
                (cur_op inside {bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16,
                                bxe_pkg::BXE_CRD_DPTR, bxe_pkg::BXE_CRD_PC});
        end
    end

    // accumulator: sole destination of external and table reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc <= bxe_pkg::ACC_RESET;
        end else if (state == BXE_FINISH && cur_op inside
                     {bxe_pkg::BXE_XRD_PTR8, bxe_pkg::BXE_XRD_PTR16}) begin
            acc <= ext_din;
        end else if (state == BXE_FINISH && cur_op inside
                     {bxe_pkg::BXE_CRD_DPTR, bxe_pkg::BXE_CRD_PC}) begin
            acc <= code_din;
        end else if (state == BXE_IDLE && acc_load_en) begin
            acc <= acc_load;
        end
    end

    // bit write-back through the store; a write to psw bit 7 also loads carry
    always_comb begin
        bus.bit_we    = 1'b0;
        bus.bit_wdata = 1'b0;
        if (state == BXE_FINISH) begin
            unique case (cur_op)
                bxe_pkg::BXE_MOV_BIT_C: begin
                    bus.bit_we = 1'b1; bus.bit_wdata = carry;
                end
                bxe_pkg::BXE_CLR_BIT: begin
                    bus.bit_we = 1'b1; bus.bit_wdata = 1'b0;
                end
                bxe_pkg::BXE_SET_BIT: begin
                    bus.bit_we = 1'b1; bus.bit_wdata = 1'b1;
                end
                bxe_pkg::BXE_CPL_BIT: begin
                    bus.bit_we = 1'b1; bus.bit_wdata = !bit_val;
                end
                bxe_pkg::BXE_JBC: begin
                    bus.bit_we = bit_val; bus.bit_wdata = 1'b0;
                end
                default: ;
            endcase
        end
    end

    // carry as the one-bit accumulator; no exclusive-or form
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            carry <= 1'b0;
        end else if (bus.bit_we && bus.bit_addr == (bxe_pkg::PSW_ADDR | 8'(bxe_pkg::CARRY_POS))) begin
            carry <= bus.bit_wdata;
        end else if (state == BXE_FINISH) begin
            unique case (cur_op)
                bxe_pkg::BXE_AND_C:     carry <= carry & bit_val;
                bxe_pkg::BXE_ANDN_C:    carry <= carry & !bit_val;
                bxe_pkg::BXE_OR_C:      carry <= carry | bit_val;
                bxe_pkg::BXE_ORN_C:     carry <= carry | !bit_val;
                bxe_pkg::BXE_MOV_C_BIT: carry <= bit_val;
                bxe_pkg::BXE_CLR_C:     carry <= 1'b0;
                bxe_pkg::BXE_SET_C:     carry <= 1'b1;
                bxe_pkg::BXE_CPL_C:     carry <= !carry;
                default:                carry <= carry;
            endcase
        end
    end

    // bit-test jumps with signed relative offset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_out  <= '0;
            pc_load <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            if (state == BXE_FINISH) begin
                pc_out <= pc_next + {{8{cur_rel[7]}}, cur_rel};
                unique case (cur_op)
                    bxe_pkg::BXE_JC:  pc_load <= carry;
                    bxe_pkg::BXE_JNC: pc_load <= !carry;
                    bxe_pkg::BXE_JB, bxe_pkg::BXE_JBC: pc_load <= bit_val;
                    bxe_pkg::BXE_JNB: pc_load <= !bit_val;
                    default:          pc_load <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy   <= 1'b0;
            done   <= 1'b0;
            p0_out <= bxe_pkg::PORT_RESET;
            p0_oe  <= '0;
            p1_out <= bxe_pkg::PORT_RESET;
            p2_out <= bxe_pkg::PORT_RESET;
            p3_out <= bxe_pkg::PORT_RESET;
        end else begin
            busy   <= (state == BXE_IDLE) ? start : (state == BXE_RUN);
            done   <= state == BXE_FINISH;
            p0_out <= bus.p0;
            p0_oe  <= (state == BXE_RUN && is_xwrite(cur_op)) ? 8'hff : 8'h00;
            p1_out <= bus.p1;
            // address high byte replaces the latch during wide accesses
            p2_out <= (state == BXE_RUN &&
                (cur_op inside {bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16,
                                bxe_pkg::BXE_CRD_DPTR, bxe_pkg::BXE_CRD_PC}))
                      ? cur_addr[15:8] : bus.p2;
            p3_out <= bus.p3;
        end
    end
endmodule
`default_nettype wire

// >>> shared/bxe_bus_if.sv
// bit address, bit data and port latch bundle between executor and bit store
`default_nettype none
interface bxe_bus_if;
    logic [7:0] bit_addr;
    logic       bit_we;
    logic       bit_wdata;
    logic       bit_rdata;
    logic [7:0] program_status_word;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    modport exec (output bit_addr, bit_we, bit_wdata, input bit_rdata, program_status_word, p0, p1, p2, p3);
    modport store (input bit_addr, bit_we, bit_wdata, output bit_rdata, program_status_word, p0, p1, p2, p3);
endinterface
`default_nettype wire

// >>> shared/bxe_pkg.sv
// constants and types for the boolean and external move executor
// How it works
// - external data reached only through indirect pointers
// - wide pointer drives high byte on port 2
// - each external data move takes two cycles
// - accumulator is sole source or destination
// - data strobes active only during external moves
// - table reads use program store strobe only
// - data pointer table read fetches at acc+dptr
// - counter table read fetches at acc+next pc
// - bit addresses below 80 map to ram
// - 128 ram bits plus 40 register bits (status word and four port latches)
// - bit operands use direct bit address only
// - every port line is bit addressable
// - carry is the one-bit accumulator, writable by bit address too
// - move set clear complement and or on bits
// - no exclusive-or among the bit operations
// - bit jumps branch on one or zero
// - test-and-clear jump clears bit when taken
// - status word bits usable as jump operands
// - relative offset added as signed value
// - jump span -128 to +127 from next byte
`default_nettype none
package bxe_pkg;
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned OSC_PER_MCYCLE  = 12;
    localparam int unsigned OSC_HZ          = 12000000;
    // machine cycle at 1 MHz -> 40 clocks
    localparam int unsigned MCYCLE_CLKS     = CLK_HZ / (OSC_HZ / OSC_PER_MCYCLE);
    localparam int unsigned XMOVE_MCYCLES   = 2;
    localparam logic [7:0]  RAM_BIT_BASE    = 8'h20;
    localparam logic [7:0]  SFR_BIT_SPLIT   = 8'h80;
    localparam logic [7:0]  PSW_ADDR        = 8'hd0;
    localparam int unsigned CARRY_POS       = 7;
    localparam logic [7:0]  P0_ADDR         = 8'h80;
    localparam logic [7:0]  P1_ADDR         = 8'h90;
    localparam logic [7:0]  P2_ADDR         = 8'ha0;
    localparam logic [7:0]  P3_ADDR         = 8'hb0;
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic [7:0]  PSW_RESET       = 8'h00;
    localparam logic [7:0]  PORT_RESET      = 8'hff;

    typedef enum logic [4:0] {
        BXE_NOP,
        BXE_XRD_PTR8, BXE_XWR_PTR8, BXE_XRD_PTR16, BXE_XWR_PTR16,
        BXE_CRD_DPTR, BXE_CRD_PC,
        BXE_AND_C, BXE_ANDN_C, BXE_OR_C, BXE_ORN_C,
        BXE_MOV_C_BIT, BXE_MOV_BIT_C,
        BXE_CLR_C, BXE_CLR_BIT, BXE_SET_C, BXE_SET_BIT,
        BXE_CPL_C, BXE_CPL_BIT,
        BXE_JC, BXE_JNC, BXE_JB, BXE_JNB, BXE_JBC
    } bxe_op_t;
endpackage
`default_nettype wire

// >>> testbench/boolean_and_external_move_exec_bench.sv
// self-checking bench for the executor
`default_nettype none
module boolean_and_external_move_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int M = 3;
    typedef struct {bxe_pkg::bxe_op_t o; logic [7:0] a; int n; logic c;} bxe_step_t;
    typedef struct {bxe_pkg::bxe_op_t o; logic [7:0] a; logic [7:0] r; logic t;} bxe_jmp_t;
    logic             clk, resetn, start, ptr_sel, acc_load_en, busy, done, pc_load, carry;
    logic             p2_addr_mode, ext_rd_n, ext_wr_n, pss_n, jumped;
    bxe_pkg::bxe_op_t op;
    logic [7:0]       bit_addr, rel, r0, r1, acc_load, ext_din, code_din, acc, p0_out, p0_oe;
    logic [7:0]       p1_out, p2_out, p3_out, ext_dout;
    logic [15:0]      dptr, pc_next, pc_out, ext_addr, tgt;
    int               n_mismatch, cmp_count;
    bxe_step_t steps [18] = '{
        '{bxe_pkg::BXE_SET_BIT, 8'h05, 1, 1'b0}, '{bxe_pkg::BXE_CLR_BIT, 8'h06, 1, 1'b0},
        '{bxe_pkg::BXE_MOV_C_BIT, 8'h05, 1, 1'b1}, '{bxe_pkg::BXE_ANDN_C, 8'h05, 2, 1'b0},
        '{bxe_pkg::BXE_ORN_C, 8'h06, 2, 1'b1}, '{bxe_pkg::BXE_AND_C, 8'h06, 2, 1'b0},
        '{bxe_pkg::BXE_OR_C, 8'h05, 2, 1'b1}, '{bxe_pkg::BXE_CPL_C, 8'h00, 1, 1'b0},
        '{bxe_pkg::BXE_MOV_BIT_C, 8'h90, 2, 1'b0}, '{bxe_pkg::BXE_CPL_BIT, 8'h97, 1, 1'b0},
        '{bxe_pkg::BXE_SET_C, 8'h00, 1, 1'b1}, '{bxe_pkg::BXE_CLR_C, 8'h00, 1, 1'b0},
        '{bxe_pkg::BXE_SET_BIT, 8'hd7, 1, 1'b1}, '{bxe_pkg::BXE_CLR_BIT, 8'hd7, 1, 1'b0},
        '{bxe_pkg::BXE_SET_C, 8'h00, 1, 1'b1}, '{bxe_pkg::BXE_CPL_BIT, 8'h05, 1, 1'b1},
        '{bxe_pkg::BXE_MOV_C_BIT, 8'h05, 1, 1'b0}, '{bxe_pkg::BXE_SET_BIT, 8'hd5, 1, 1'b0}};
    bxe_jmp_t jumps [9] = '{
        '{bxe_pkg::BXE_JC, 8'h00, 8'h7f, 1'b0}, '{bxe_pkg::BXE_JNC, 8'h00, 8'h7f, 1'b1},
        '{bxe_pkg::BXE_JB, 8'h91, 8'h80, 1'b1}, '{bxe_pkg::BXE_JNB, 8'h91, 8'h10, 1'b0},
        '{bxe_pkg::BXE_JNB, 8'h05, 8'h10, 1'b1}, '{bxe_pkg::BXE_JBC, 8'h91, 8'hfe, 1'b1},
        '{bxe_pkg::BXE_JB, 8'h91, 8'h05, 1'b0}, '{bxe_pkg::BXE_JBC, 8'h05, 8'h05, 1'b0},
        '{bxe_pkg::BXE_JB, 8'hd5, 8'h02, 1'b1}};

    bxe_exec #(.MCYCLE_CLKS(M)) bxe_exec_i (
        .clk(clk), .resetn(resetn), .start(start), .op(op), .bit_addr(bit_addr), .rel(rel),
        .ptr_sel(ptr_sel), .r0(r0), .r1(r1), .dptr(dptr), .pc_next(pc_next),
        .acc_load(acc_load), .acc_load_en(acc_load_en), .ext_din(ext_din),
        .code_din(code_din), .busy(busy), .done(done), .pc_out(pc_out), .pc_load(pc_load),
        .acc(acc), .carry(carry), .p0_out(p0_out), .p0_oe(p0_oe), .p1_out(p1_out),
        .p2_out(p2_out), .p2_addr_mode(p2_addr_mode), .p3_out(p3_out), .ext_addr(ext_addr),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .program_store_strobe_n(pss_n),
        .ext_dout(ext_dout));
    bxe_xmem_model bxe_xmem_model_i (
        .clk(clk), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .program_store_strobe_n(pss_n), .ext_dout(ext_dout), .ext_din(ext_din),
        .code_din(code_din));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic load_acc(input logic [7:0] v);
        @(posedge clk);
        #1 acc_load = v;
        acc_load_en = 1'b1;
        @(posedge clk);
        #1 acc_load_en = 1'b0;
    endtask
    // issue one op, wait for done, check its length
    task automatic run(input bxe_pkg::bxe_op_t o, input logic [7:0] ba, input logic [7:0] rl,
                       input int n_mc);
        int n;
        @(posedge clk);
        #1 op = o;
        bit_addr = ba;
        rel = rl;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        jumped = pc_load;
        tgt = pc_out;
        chk(16'(n), 16'(n_mc * M + 2), "latency");
    endtask
    task automatic t_xmove();
        dptr = 16'h1234;
        r0 = 8'h77;
        r1 = 8'h34;
        ptr_sel = 1'b1;
        load_acc(8'h5a);
        run(bxe_pkg::BXE_XWR_PTR16, 8'h00, 8'h00, 2);
        load_acc(8'hc3);
        run(bxe_pkg::BXE_XWR_PTR8, 8'h00, 8'h00, 2);
        load_acc(8'h00);
        run(bxe_pkg::BXE_XRD_PTR16, 8'h00, 8'h00, 2);
        chk(16'(acc), 16'h005a, "wide read");
        run(bxe_pkg::BXE_XRD_PTR8, 8'h00, 8'h00, 2);
        chk(16'(acc), 16'h00c3, "short read");
        $display("test xmove finished");
    endtask
    task automatic t_table();
        dptr = 16'h10f0;
        load_acc(8'hff);
        run(bxe_pkg::BXE_CRD_DPTR, 8'h00, 8'h00, 2);
        chk(16'(acc), 16'(8'hef ^ 8'h11 ^ 8'h5c), "dptr table");
        pc_next = 16'h20fe;
        load_acc(8'h05);
        run(bxe_pkg::BXE_CRD_PC, 8'h00, 8'h00, 2);
        chk(16'(acc), 16'(8'h03 ^ 8'h21 ^ 8'h5c), "pc table");
        $display("test table finished");
    endtask
    task automatic t_bits();
        foreach (steps[i]) begin
            run(steps[i].o, steps[i].a, 8'h00, steps[i].n);
            chk(16'(carry), 16'(steps[i].c), "carry");
        end
        chk(16'(p1_out), 16'h007e, "port bits");
        $display("test bits finished");
    endtask
    task automatic t_jumps();
        pc_next = 16'h0100;
        foreach (jumps[i]) begin
            run(jumps[i].o, jumps[i].a, jumps[i].r, 2);
            chk(16'(jumped), 16'(jumps[i].t), "taken");
            if (jumps[i].t) begin
                chk(tgt, pc_next + {{8{jumps[i].r[7]}}, jumps[i].r}, "target");
            end
        end
        chk(16'(p1_out), 16'h007c, "cleared bit");
        $display("test jumps finished");
    endtask
    task automatic close_out();
        $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        {resetn, start, ptr_sel, acc_load_en} = 4'h0;
        op = bxe_pkg::BXE_NOP;
        {bit_addr, rel, r0, r1, acc_load} = 40'h0;
        {dptr, pc_next} = 32'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        t_xmove();
        t_table();
        t_bits();
        t_jumps();
        close_out();
    end
endmodule
`default_nettype wire

// >>> testbench/bxe_exec_sva.sv
// port-level assertions for the executor
`default_nettype none
module bxe_exec_sva #(
    parameter int unsigned MCYCLE_CLKS = 3
) (
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             start,
    input wire bxe_pkg::bxe_op_t op,
    input wire logic [7:0]       rel,
    input wire logic [15:0]      pc_next,
    input wire logic             busy,
    input wire logic             done,
    input wire logic [15:0]      pc_out,
    input wire logic             pc_load,
    input wire logic [7:0]       acc,
    input wire logic             carry,
    input wire logic [7:0]       p0_oe,
    input wire logic [7:0]       p2_out,
    input wire logic             p2_addr_mode,
    input wire logic [15:0]      ext_addr,
    input wire logic             ext_rd_n,
    input wire logic             ext_wr_n,
    input wire logic             program_store_strobe_n,
    input wire logic [7:0]       ext_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D1 = MCYCLE_CLKS + 2;
    localparam int D2 = 2 * MCYCLE_CLKS + 2;
    bxe_pkg::bxe_op_t cur_op;
    logic [15:0]      tgt;
    logic             ptr8;
    logic             xmv;
    // remember the accepted operation and its jump target
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_op <= bxe_pkg::BXE_NOP;
            tgt    <= 16'h0000;
        end else if (start && !busy) begin
            cur_op <= op;
            tgt    <= pc_next + {{8{rel[7]}}, rel};
        end
    end
    assign ptr8 = cur_op inside {bxe_pkg::BXE_XRD_PTR8, bxe_pkg::BXE_XWR_PTR8};
    assign xmv  = ptr8 || cur_op inside {bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_busy_on_start: assert property (start && !busy |=> busy)
        else $error("busy not raised after start");
    a_two_cycle_move: assert property (start && !busy && op inside {bxe_pkg::BXE_XRD_PTR8,
        bxe_pkg::BXE_XWR_PTR8, bxe_pkg::BXE_XRD_PTR16, bxe_pkg::BXE_XWR_PTR16}
        |=> !done [*2] ##(D2 - 2) done)
        else $error("external move not two machine cycles");
    a_one_cycle_bit: assert property (start && !busy && op inside {bxe_pkg::BXE_CLR_C,
        bxe_pkg::BXE_SET_C, bxe_pkg::BXE_CPL_C, bxe_pkg::BXE_CLR_BIT, bxe_pkg::BXE_SET_BIT,
        bxe_pkg::BXE_CPL_BIT, bxe_pkg::BXE_MOV_C_BIT} |-> ##D1 done)
        else $error("short bit op not one machine cycle");
    a_strobe_in_move: assert property (!ext_rd_n || !ext_wr_n |-> busy && xmv)
        else $error("data strobe outside external move");
    a_read_to_acc: assert property (!ext_rd_n |-> ext_wr_n && (cur_op inside
        {bxe_pkg::BXE_XRD_PTR8, bxe_pkg::BXE_XRD_PTR16}))
        else $error("read strobe on a write");
    a_write_from_acc: assert property (!ext_wr_n |-> ext_dout == acc && p0_oe == 8'hff)
        else $error("written byte is not acc");
    a_table_strobe: assert property (!program_store_strobe_n |-> ext_rd_n && ext_wr_n
        && (cur_op inside {bxe_pkg::BXE_CRD_DPTR, bxe_pkg::BXE_CRD_PC}))
        else $error("program strobe misused");
    a_short_page: assert property ((!ext_rd_n || !ext_wr_n) && ptr8
        |-> ext_addr[15:8] == 8'h00 && !p2_addr_mode)
        else $error("short pointer took port 2");
    a_port2_addr: assert property (p2_addr_mode |-> p2_out == ext_addr[15:8])
        else $error("port 2 not carrying high address");
    a_jump_target: assert property (pc_load |-> done && pc_out == tgt)
        else $error("jump target wrong");
    a_set_carry: assert property (done && cur_op == bxe_pkg::BXE_SET_C |-> carry)
        else $error("carry not set");
    c_move: cover property (done && xmv);
    c_jump: cover property (pc_load);
    c_table: cover property (!program_store_strobe_n);
endmodule
bind bxe_exec bxe_exec_sva #(.MCYCLE_CLKS(MCYCLE_CLKS)) bxe_exec_sva_i (
    .clk(clk), .resetn(resetn), .start(start), .op(op), .rel(rel), .pc_next(pc_next),
    .busy(busy), .done(done), .pc_out(pc_out), .pc_load(pc_load), .acc(acc),
    .carry(carry), .p0_oe(p0_oe), .p2_out(p2_out), .p2_addr_mode(p2_addr_mode),
    .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .program_store_strobe_n(program_store_strobe_n), .ext_dout(ext_dout));
`default_nettype wire

// >>> testbench/bxe_xmem_model.sv
// external data ram and program memory on the far side
`default_nettype none
module bxe_xmem_model (
    input  wire logic        clk,
    input  wire logic [15:0] ext_addr,
    input  wire logic        ext_rd_n,
    input  wire logic        ext_wr_n,
    input  wire logic        program_store_strobe_n,
    input  wire logic [7:0]  ext_dout,
    output logic [7:0]       ext_din,
    output logic [7:0]       code_din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [0:65535];
    logic       hold_d;
    logic       hold_c;
    always_ff @(posedge clk) begin
        if (!ext_wr_n) begin
            ram[ext_addr] <= ext_dout;
        end
    end
    // slow answer, one cycle of hold, then a toggling bus
    always_ff @(posedge clk) begin
        hold_d  <= !ext_rd_n;
        ext_din <= !ext_rd_n ? ram[ext_addr] : (hold_d ? ext_din : ~ext_din);
    end
    // program store is read only
    always_ff @(posedge clk) begin
        hold_c   <= !program_store_strobe_n;
        code_din <= !program_store_strobe_n ? ext_addr[7:0] ^ ext_addr[15:8] ^ 8'h5c
                  : (hold_c ? code_din : ~code_din);
    end
endmodule
`default_nettype wire
